// ---- rtl/clkdiv_pkg.sv ----
// constants shared by the cascaded channel divider and its stages
package clkdiv_pkg;
   // ---------------------------------------------------------------
   // register bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int FIELD_W = 4;          // width of one count field
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_DIV1 = 4'h0;   // first stage counts
   localparam logic [3:0] ADDR_DIV2 = 4'h1;   // second stage counts
   localparam logic [3:0] ADDR_CTRL = 4'h2;   // bypass, correction, source
   localparam logic [3:0] ADDR_VCO = 4'h3;    // vco divider ratio
   localparam logic [3:0] ADDR_STAT = 4'h4;   // constraint flag, level
   localparam logic [3:0] ADDR_RATIO = 4'h5;  // total channel division
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int LOW_LSB = 4;          // low-cycle count, upper nibble
   localparam int HIGH_LSB = 0;         // high-cycle count, lower nibble
   localparam int CTRL_BYP1 = 0;
   localparam int CTRL_BYP2 = 1;
   localparam int CTRL_DCC_OFF = 2;
   localparam int CTRL_VCO_SEL = 3;
   localparam int CTRL_W = 4;
   localparam int VCO_W = 3;
   localparam int RATIO_W = 11;
   // ---------------------------------------------------------------
   // reset values and count offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [3:0] CTRL_RST = 4'h0;    // correction on by default
   localparam logic [2:0] VCO_RST = 3'h2;
   localparam logic [2:0] VCO_MIN = 3'h2;
   localparam int CNT_BIAS = 1;         // fields hold cycles minus one
   localparam int MAX_RATIO = 1024;
endpackage

// ---- rtl/stage_if.sv ----
// carrier between the channel top and one counting stage
`timescale 1ns/1ns
interface stage_if #(parameter int W = 4);
   logic in_rise;            // input clock rising edge, one cycle
   logic in_fall;            // input clock falling edge, one cycle
   logic [W-1:0] high_cnt;   // high cycles minus one
   logic [W-1:0] low_cnt;    // low cycles minus one
   logic dcc_on;             // duty-cycle correction enabled
   logic out_level;          // stage output level
   logic out_rise;           // stage output rising edge
   logic out_fall;           // stage output falling edge
   modport stage (input in_rise, in_fall, high_cnt, low_cnt, dcc_on,
                  output out_level, out_rise, out_fall);
   modport ctrl (output in_rise, in_fall, high_cnt, low_cnt, dcc_on,
                 input out_level, out_rise, out_fall);
endinterface

// ---- rtl/divider_stage.sv ----
// one programmable high/low counting stage with duty-cycle correction
`timescale 1ns/1ns
module divider_stage #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic nrst,
   stage_if.stage s
);
   import clkdiv_pkg::*;

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (W < 1 || W > 8) begin : g_bad_width
      $error("divider_stage: field width not supported");
   end

   // ---------------------------------------------------------------
   // counting datapath
   // ---------------------------------------------------------------
   logic [W+1:0] cnt;         // input rises since output rose
   logic pend;                // odd corrected: fall waits for input fall
   logic out_level;
   logic out_rise;
   logic out_fall;
   wire logic [W+1:0] d_total; // whole division of this stage
   wire logic dcc_odd;
   wire logic wrap;
   wire logic high_end;
   wire logic [W+1:0] next_cnt;
   wire logic next_out;
   wire logic next_pend;

   // R10 counts are cycles minus one
   assign d_total = (W+2)'(s.high_cnt) + (W+2)'(s.low_cnt)
                  + (W+2)'(2 * CNT_BIAS);
   // R08 correction only acts on an odd division
   assign dcc_odd = s.dcc_on & d_total[0];
   // >= so a count left over from a longer setting restarts on the next input rise
   assign wrap = s.in_rise && (cnt >= d_total - (W+2)'(CNT_BIAS));
   assign high_end = s.in_rise && !wrap && (cnt == (W+2)'(s.high_cnt));
   assign next_cnt = wrap ? '0 : (s.in_rise ? cnt + 1'b1 : cnt);
   // R06 uncorrected: high for high count plus one cycles
   // R09 corrected odd: fall on the input fall, adding the input high
   assign next_out = wrap ? 1'b1 :
                     (high_end && !dcc_odd) ? 1'b0 :
                     (s.in_fall && pend) ? 1'b0 : out_level;
   assign next_pend = wrap ? 1'b0 :
                      (high_end && dcc_odd) ? 1'b1 :
                      s.in_fall ? 1'b0 : pend;

   // state and edge pulses, aligned with the registered level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
         pend <= 1'b0;
         out_level <= 1'b0;
         out_rise <= 1'b0;
         out_fall <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pend <= next_pend;
         out_level <= next_out;
         out_rise <= next_out & ~out_level;
         out_fall <= ~next_out & out_level;
      end
   end

   assign s.out_level = out_level;
   assign s.out_rise = out_rise;
   assign s.out_fall = out_fall;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_plain_fall: assert property (@(posedge core_clk) disable iff (!nrst) // R06
      high_end && !dcc_odd |=> !out_level && out_fall == $past(out_level))
      else $error("uncorrected stage did not fall after high count");
   a_odd_hold: assert property (@(posedge core_clk) disable iff (!nrst) // R08
      high_end && dcc_odd && !s.in_fall |=>
      pend && out_level == $past(out_level))
      else $error("corrected odd stage fell early");
   a_odd_fall: assert property (@(posedge core_clk) disable iff (!nrst) // R09
      s.in_fall && pend && !wrap |=> !out_level ##1 !out_fall)
      else $error("corrected odd stage missed input fall");
   a_period_wrap: assert property (@(posedge core_clk) disable iff (!nrst) // R11
      wrap |=> out_level && cnt == '0)
      else $error("stage period did not restart");
   c_odd_fix: cover property (@(posedge core_clk) disable iff (!nrst)
      high_end && dcc_odd ##[1:8] !out_level);
endmodule

// ---- rtl/cascaded_channel_divider_dcc.sv ----
// cascaded two-stage channel divider with vco divider and duty correction
//
// Contract
// R01 - even stage corrected needs equal counts
// R02 - odd stage corrected: low exceeds high by one
// R03 - single bypassed stage must be second
// R04 - single even stage must be second
// R05 - uncorrected bypass passes input or first stage
// R06 - uncorrected cascade duty set by second stage
// R07 - vco divider alone: 50, 33.3, 40 percent
// R08 - corrected path gives 50 percent duty
// R09 - corrected odd vco adds input high time
// R10 - low count upper nibble, high lower
// R11 - division is product, bypass counts one
// R12 - correction on after reset, disable bit
`timescale 1ns/1ns
module cascaded_channel_divider_dcc (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ref_level,          // sampled divider input clock
   input wire logic [clkdiv_pkg::ADDR_W-1:0] addr,
   input wire logic [clkdiv_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [clkdiv_pkg::DATA_W-1:0] rdata,
   output logic chan_out                // lvds/cmos channel output level
);
   import clkdiv_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // whole division of one stage; a bypassed stage divides by one
   function automatic logic [RATIO_W-1:0] stage_total(
      input logic bypass, input logic [7:0] div);
      logic [RATIO_W-1:0] t;
      t = RATIO_W'(div[LOW_LSB +: FIELD_W]) + RATIO_W'(div[HIGH_LSB +:
          FIELD_W]) + RATIO_W'(2 * CNT_BIAS);
      stage_total = bypass ? RATIO_W'(CNT_BIAS) : t;
   endfunction

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [7:0] div1;            // first stage low/high counts
   logic [7:0] div2;            // second stage low/high counts
   logic [CTRL_W-1:0] ctrl;     // bypass bits, correction disable, source
   logic [VCO_W-1:0] vco_ratio; // vco divider ratio
   wire logic bypass1 = ctrl[CTRL_BYP1];
   wire logic bypass2 = ctrl[CTRL_BYP2];
   wire logic duty_correction_disable = ctrl[CTRL_DCC_OFF];
   wire logic vco_sel = ctrl[CTRL_VCO_SEL];
   // R12 correction follows the disable bit for every stage
   wire logic dcc_on = ~duty_correction_disable;

   // software writes, one cycle each, never stalled
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div1 <= DIV_RST;
         div2 <= DIV_RST;
         ctrl <= CTRL_RST;
         vco_ratio <= VCO_RST;
      end else if (wr) begin
         case (addr)
            ADDR_DIV1: div1 <= wdata[7:0];
            ADDR_DIV2: div2 <= wdata[7:0];
            ADDR_CTRL: ctrl <= wdata[CTRL_W-1:0];
            ADDR_VCO: vco_ratio <= wdata[VCO_W-1:0];
            default: ;   // read-only or unmapped: ignored
         endcase
      end
   end

   // ---------------------------------------------------------------
   // input edges and vco divider
   // ---------------------------------------------------------------
   logic ref_prev;              // last sampled input level
   wire logic ref_rise = ref_level & ~ref_prev;
   wire logic ref_fall = ~ref_level & ref_prev;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ref_prev <= 1'b0;
      end else begin
         ref_prev <= ref_level;
      end
   end

   // ratios below two are treated as two, the divider has no bypass
   wire logic [VCO_W-1:0] vco_eff =
      (vco_ratio < VCO_MIN) ? VCO_MIN : vco_ratio;
   // R07 uncorrected odd vco division stays high for the floor half
   wire logic [VCO_W-1:0] vco_high = (vco_eff >> 1) - VCO_W'(CNT_BIAS);
   wire logic [VCO_W-1:0] vco_low =
      vco_eff - (vco_eff >> 1) - VCO_W'(CNT_BIAS);

   stage_if #(.W(FIELD_W)) vco_s ();
   stage_if #(.W(FIELD_W)) st1 ();
   stage_if #(.W(FIELD_W)) st2 ();

   assign vco_s.in_rise = ref_rise;
   assign vco_s.in_fall = ref_fall;
   assign vco_s.high_cnt = FIELD_W'(vco_high);
   assign vco_s.low_cnt = FIELD_W'(vco_low);
   // R09 corrected odd vco division picks up the input high time
   assign vco_s.dcc_on = dcc_on;

   // ---------------------------------------------------------------
   // source selection and cascade
   // ---------------------------------------------------------------
   // R07 raw input or vco divider output feeds the first stage
   wire logic src_level = vco_sel ? vco_s.out_level : ref_level;
   wire logic src_rise = vco_sel ? vco_s.out_rise : ref_rise;
   wire logic src_fall = vco_sel ? vco_s.out_fall : ref_fall;

   // R10 low count in upper nibble, high count in lower
   assign st1.in_rise = src_rise;
   assign st1.in_fall = src_fall;
   assign st1.low_cnt = div1[LOW_LSB +: FIELD_W];
   assign st1.high_cnt = div1[HIGH_LSB +: FIELD_W];
   assign st1.dcc_on = dcc_on;

   // R05 a bypassed first stage passes its input through
   wire logic mid_level = bypass1 ? src_level : st1.out_level;
   wire logic mid_rise = bypass1 ? src_rise : st1.out_rise;
   wire logic mid_fall = bypass1 ? src_fall : st1.out_fall;

   assign st2.in_rise = mid_rise;
   assign st2.in_fall = mid_fall;
   assign st2.low_cnt = div2[LOW_LSB +: FIELD_W];
   assign st2.high_cnt = div2[HIGH_LSB +: FIELD_W];
   assign st2.dcc_on = dcc_on;

   // R06 with both stages active the second one sets the duty
   wire logic fin_level = bypass2 ? mid_level : st2.out_level;

   divider_stage #(.W(FIELD_W)) u_vco (
      .core_clk(core_clk),
      .nrst(nrst),
      .s(vco_s.stage)
   );
   divider_stage #(.W(FIELD_W)) u_st1 (
      .core_clk(core_clk),
      .nrst(nrst),
      .s(st1.stage)
   );
   divider_stage #(.W(FIELD_W)) u_st2 (
      .core_clk(core_clk),
      .nrst(nrst),
      .s(st2.stage)
   );

   // output pin from a flop so it never glitches on a mux change
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         chan_out <= 1'b0;
      end else begin
         chan_out <= fin_level;
      end
   end

   // ---------------------------------------------------------------
   // status: division and correction constraints
   // ---------------------------------------------------------------
   // R11 channel division is the product of the stage divisions
   wire logic [RATIO_W-1:0] d1 = stage_total(bypass1, div1);
   wire logic [RATIO_W-1:0] d2 = stage_total(bypass2, div2);
   wire logic [2*RATIO_W-1:0] ratio_full = d1 * d2;
   wire logic [RATIO_W-1:0] ratio = ratio_full[RATIO_W-1:0];

   // R01 R02 count shape per active stage; reported, not enforced
   wire logic shape1 = bypass1 || (d1[0] ? (st1.low_cnt ==
      st1.high_cnt + FIELD_W'(CNT_BIAS)) : (st1.low_cnt == st1.high_cnt));
   wire logic shape2 = bypass2 || (d2[0] ? (st2.low_cnt ==
      st2.high_cnt + FIELD_W'(CNT_BIAS)) : (st2.low_cnt == st2.high_cnt));
   // R03 the lone bypassed stage must be the second
   wire logic byp_ok = !(bypass1 && !bypass2);
   // R04 a lone even stage must be the second
   wire logic even_ok = bypass1 || bypass2 || !(!d1[0] && d2[0]);
   wire logic dcc_ok = shape1 && shape2 && byp_ok && even_ok;

   // ---------------------------------------------------------------
   // read path: data stand only in the cycle after the strobe
   // ---------------------------------------------------------------
   wire logic [DATA_W-1:0] rd_mux =
      (addr == ADDR_DIV1) ? DATA_W'(div1) :
      (addr == ADDR_DIV2) ? DATA_W'(div2) :
      (addr == ADDR_CTRL) ? DATA_W'(ctrl) :
      (addr == ADDR_VCO) ? DATA_W'(vco_ratio) :
      (addr == ADDR_STAT) ? DATA_W'({chan_out, dcc_ok}) :
      (addr == ADDR_RATIO) ? DATA_W'(ratio) : '0;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? rd_mux : '0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_bypass_pass: assert property (@(posedge core_clk) disable iff (!nrst) // R05
      bypass1 && bypass2 && !vco_sel |=> chan_out == $past(ref_level))
      else $error("bypassed channel did not follow input");
   a_vco_route: assert property (@(posedge core_clk) disable iff (!nrst) // R07
      vco_sel && bypass1 && bypass2 |=> chan_out == $past(vco_s.out_level))
      else $error("vco divider not routed to output");
   a_ratio_range: assert property (@(posedge core_clk) disable iff (!nrst) // R11
      ratio <= RATIO_W'(MAX_RATIO) &&
      (!(bypass1 && bypass2) || ratio == RATIO_W'(CNT_BIAS)))
      else $error("channel division out of range");
   a_dcc_default: assert property (@(posedge core_clk) // R12
      $rose(nrst) |-> dcc_on ##1 (dcc_on || $past(wr)))
      else $error("correction not enabled after reset");
   c_cascade: cover property (@(posedge core_clk) disable iff (!nrst)
      !bypass1 && !bypass2 && dcc_ok ##1 $rose(chan_out));
   c_bypass2: cover property (@(posedge core_clk) disable iff (!nrst)
      !bypass1 && bypass2 && vco_sel ##1 $fell(chan_out));
endmodule

// ---- verif/cascaded_channel_divider_dcc_bench.sv ----
// self-checking bench for the cascaded channel divider with correction
`timescale 1ns/1ns
module cascaded_channel_divider_dcc_bench;
   import clkdiv_pkg::*;
   // ---------------------------------------------------------------
   // control word pieces and limits
   // ---------------------------------------------------------------
   localparam logic [15:0] byp1 = 16'h0001 << CTRL_BYP1;
   localparam logic [15:0] byp2 = 16'h0001 << CTRL_BYP2;
   localparam logic [15:0] c_off = 16'h0001 << CTRL_DCC_OFF;
   localparam logic [15:0] vco_on = 16'h0001 << CTRL_VCO_SEL;
   localparam int cycle_limit = 20000;  // tests need about 1000
   logic core_clk = 1'b0;
   logic nrst = 1'b0;                   // held low for 3 cycles
   logic ref_level = 1'b0;              // divider input clock
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic chan_out;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int ref_hi = 2;                      // input samples high per period
   int ref_lo = 2;                      // input samples low per period
   int ph = 0;                          // phase within input period
   // ---------------------------------------------------------------
   // device, clock, input clock and watchdog
   // ---------------------------------------------------------------
   cascaded_channel_divider_dcc cascaded_channel_divider_dcc_i (
      .core_clk(core_clk), .nrst(nrst), .ref_level(ref_level),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .chan_out(chan_out));
   always #50 core_clk = ~core_clk;
   // input clock; wrap with >= so a shorter period never overruns
   always @(posedge core_clk) begin
      if (ph + 1 >= ref_hi + ref_lo) ph <= 0;
      else ph <= ph + 1;
      ref_level <= (ph < ref_hi);
   end
   // a hang counts as a mismatch and closes the run
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == cycle_limit) begin
         fails = fails + 1;
         report_and_stop();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("counts: %0d compared, %0d bad", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [15:0] m,
                       input logic [15:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      chk(rdata & m, exp);
   endtask
   task automatic cfg(input logic [15:0] d1, input logic [15:0] d2,
                      input logic [15:0] c, input logic [15:0] v,
                      input int h, input int l);
      wr_reg(ADDR_DIV1, d1);
      wr_reg(ADDR_DIV2, d2);
      wr_reg(ADDR_CTRL, c);
      wr_reg(ADDR_VCO, v);
      ref_hi <= h;
      ref_lo <= l;
   endtask
   task automatic wait_lvl(input logic v);
      int n = 0;
      while (chan_out !== v && n < 400) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   // skip settling periods, then count one high and one low phase
   task automatic measure(input int eh, input int el);
      int hi = 0;
      int lo = 0;
      // step off the launching edge before looking at the output
      @(negedge core_clk);
      repeat (3) begin
         wait_lvl(1'b0);
         wait_lvl(1'b1);
      end
      while (chan_out === 1'b1 && hi < 400) begin
         hi++;
         @(negedge core_clk);
      end
      while (chan_out === 1'b0 && lo < 400) begin
         lo++;
         @(negedge core_clk);
      end
      chk(16'(hi), 16'(eh));
      chk(16'(lo), 16'(el));
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rchk(ADDR_CTRL, 16'hffff, 16'h0000);  // correction on
      rchk(ADDR_DIV1, 16'hffff, 16'h0000);
      rchk(ADDR_VCO, 16'hffff, 16'h0002);
      rchk(ADDR_RATIO, 16'hffff, 16'h0004);
      rchk(4'hf, 16'hffff, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_regs();
      wr_reg(ADDR_DIV1, 16'h0021);
      rchk(ADDR_DIV1, 16'hffff, 16'h0021);
      // read-only total must ignore the write
      wr_reg(ADDR_RATIO, 16'h0123);
      rchk(ADDR_RATIO, 16'hffff, 16'h000a);
      wr_reg(ADDR_CTRL, byp2);
      rchk(ADDR_RATIO, 16'hffff, 16'h0005);
      wr_reg(ADDR_CTRL, byp1 | byp2);
      rchk(ADDR_RATIO, 16'hffff, 16'h0001);
      cfg(16'h00ff, 16'h00ff, 16'h0000, 16'h0002, 2, 2);
      rchk(ADDR_RATIO, 16'hffff, 16'h0400);  // largest
      $display("register access done");
   endtask
   task automatic t_flags();
      cfg(16'h0000, 16'h0021, byp1, 16'h0002, 2, 2);
      rchk(ADDR_STAT, 16'h0001, 16'h0000);
      cfg(16'h0011, 16'h0021, 16'h0000, 16'h0002, 2, 2);
      rchk(ADDR_STAT, 16'h0001, 16'h0000);
      cfg(16'h0020, 16'h0000, byp2, 16'h0002, 2, 2);
      rchk(ADDR_STAT, 16'h0001, 16'h0000);
      wr_reg(ADDR_DIV1, 16'h0030);
      rchk(ADDR_STAT, 16'h0001, 16'h0000);
      wr_reg(ADDR_DIV1, 16'h0021);
      rchk(ADDR_STAT, 16'h0001, 16'h0001);
      $display("constraint flag done");
   endtask
   task automatic t_uncorr();
      cfg(16'h0021, 16'h0000, c_off | byp1 | byp2, 16'h0002, 3, 1);
      measure(3, 1);  // input duty passes
      cfg(16'h0021, 16'h0000, c_off | byp2, 16'h0002, 2, 2);
      measure(8, 12);  // first stage only
      cfg(16'h0000, 16'h0020, c_off, 16'h0002, 1, 1);
      measure(4, 12);  // second stage sets duty
      $display("uncorrected duty done");
   endtask
   task automatic t_vco();
      cfg(16'h0000, 16'h0000, c_off | vco_on | byp1 | byp2, 16'h0002, 2, 2);
      measure(4, 4);  // even ratio
      wr_reg(ADDR_VCO, 16'h0003);
      measure(4, 8);  // one third
      wr_reg(ADDR_VCO, 16'h0005);
      measure(8, 12);  // two fifths
      $display("vco divider done");
   endtask
   task automatic t_corr();
      cfg(16'h0021, 16'h0000, byp2, 16'h0002, 2, 2);
      measure(10, 10);  // odd first stage
      cfg(16'h0021, 16'h0000, 16'h0000, 16'h0002, 1, 1);
      measure(10, 10);  // cascade
      cfg(16'h0000, 16'h0000, vco_on | byp1 | byp2, 16'h0003, 2, 2);
      measure(6, 6);  // odd vco
      $display("corrected duty done");
   endtask
   // uneven input (three of four high) leaks through an odd vco ratio
   task automatic t_skew();
      cfg(16'h0000, 16'h0000, vco_on | byp1 | byp2, 16'h0003, 3, 1);
      measure(7, 5);  // divide by three
      wr_reg(ADDR_VCO, 16'h0005);
      measure(11, 9);  // divide by five
      cfg(16'h0000, 16'h0000, vco_on | byp2, 16'h0003, 3, 1);
      measure(12, 12);  // even stage restores
      $display("uneven input done");
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_regs();
      t_flags();
      t_uncorr();
      t_vco();
      t_corr();
      t_skew();
      report_and_stop();
   end
endmodule
